/* core/pmc_core.sv */
// misc mode control: power-down, isolate, resets, carrier, link, loopback
`timescale 1ns/1ps
`default_nettype none
module pmc_core #(
	parameter int LINK_WAIT = pmc_pkg::LINK_WAIT_CYC // line settle count
) (
	input  wire logic        pclk,           // system clock
	input  wire logic        presetn,        // hardware reset, active low
	input  wire logic        psel,           // apb select
	input  wire logic        penable,        // apb enable
	input  wire logic        pwrite,         // apb direction
	input  wire logic [7:0]  paddr,          // apb byte address
	input  wire logic [31:0] pwdata,         // apb write data
	output logic      [31:0] prdata,         // apb read data
	output logic             pready,         // apb ready
	output logic             pslverr,        // apb error
	input  wire logic        rmii_strap,     // mode strap, caught at reset
	input  wire logic        link_clk,       // mac side bit clock
	input  wire logic        tx_en,          // mac transmit enable
	input  wire logic        tx_er,          // mac transmit error
	input  wire logic [3:0]  txd,            // mac transmit data
	input  wire logic        rx_code_bit,    // encoded receive bit
	input  wire logic        rx_line_dv,     // line receive valid
	input  wire logic [3:0]  rx_line_d,      // line receive data
	input  wire logic        mlt3_signal_valid, // 100 mbit waveform ok
	input  wire logic        link10_ok,      // 10 mbit receiver link
	input  wire logic        line_energy_in, // energy seen on the line
	output logic             rx_dv,          // receive valid to mac
	output logic      [3:0]  rxd,            // receive data to mac
	output logic             crs,            // carrier sense, mii
	output logic             crs_dv,         // carrier sense, rmii
	output logic             col,            // collision
	output logic             line_tx_en,     // transmit to line
	output logic             line_tx_er,     // transmit error to line
	output logic      [3:0]  line_txd,       // transmit data to line
	output logic             tx_power_down,  // transmitters off
	output logic             core_power_down, // analog core off
	output logic             mac_clk_fast,   // 25 mhz when set
	output logic             link_data_enable, // link up, paths active
	output logic             link_activity_led, // link indication
	output logic             interrupt_out_n // interrupt, active low
);
	// two-stage synchroniser pair
	typedef struct packed {
		logic s1; // first stage
		logic s2; // second stage
	} pmc_sync_t;

	// all state of the block
	typedef struct packed {
		pmc_sync_t        lclk, ten, ter, rxb, rdv, mlt, l10, nrg, strap;
		logic [3:0]       txd1, txd2, rd1, rd2;  // bus synchronisers
		logic             lclk_q;     // previous link clock level
		logic [pmc_pkg::CTL_W-1:0] ctl; // basic control
		logic             edpd;       // power-down enable, soft exempt
		logic             farlb;      // far loopback enable
		logic             imask;      // energy interrupt mask
		logic             iflag;      // energy interrupt sticky
		logic             nrg_q;      // previous energy level
		logic             rmii;       // caught mode strap
		logic             strap_done; // strap caught since reset
		logic [8:0]       boot_cnt;   // slow clock timer
		pmc_pkg::pmc_link_t link_st;  // link monitor state
		logic [13:0]      link_cnt;   // settle timer
		logic [9:0]       win;        // last ten code bits
		pmc_pkg::pmc_cs_t cs_st;      // carrier state
		logic [2:0]       sym_cnt;    // bit within symbol
		logic             tx_act;     // accepted transmit activity
		logic             rx_crs;     // receive carrier
		logic             crs;        // output carrier
		logic             col;        // output collision
		logic             rxdv;       // data to mac
		logic [3:0]       rxd;
		logic             ltxen;      // data to line
		logic             ltxer;
		logic [3:0]       ltxd;
		logic [31:0]      prdata;     // read data for access phase
	} pmc_state_t;

	pmc_state_t st_reg;  // registered state
	pmc_state_t st_next; // next state

	// true when two zeros with a gap sit in the window
	function automatic logic gap_zeros(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 10; i++)
		begin
			for (int j = i + 2; j < 10; j++)
			begin
				if (!w[i] && !w[j])
					hit = 1'b1;
			end
		end
		return hit;
	endfunction : gap_zeros

	// shift a pin through a synchroniser
	function automatic pmc_sync_t sync2(input pmc_sync_t s, input logic d);
		pmc_sync_t r;
		r.s1 = d;
		r.s2 = s.s1;
		return r;
	endfunction : sync2

	logic       acc;       // apb access phase
	logic       setup;     // apb setup phase
	logic       mapped;    // address decodes
	logic       wr;        // write takes effect
	logic       lc_rise;   // link clock rising edge
	logic       link_ok;   // combined link status
	logic       pdn;       // energy detect power-down active
	logic       far_on;    // far loopback in effect
	logic       mac_cut;   // mac transmit ignored
	logic [4:0] last_sym;  // symbol just completed
	logic [3:0] lst_bits;  // link state for readback

	assign acc      = psel & penable;
	assign setup    = psel & ~penable;
	assign mapped   = (paddr == pmc_pkg::OFF_CTRL) ||
		(paddr == pmc_pkg::OFF_MODE) || (paddr == pmc_pkg::OFF_STAT) ||
		(paddr == pmc_pkg::OFF_IMASK) || (paddr == pmc_pkg::OFF_ISRC);
	assign wr       = acc & pwrite & mapped;
	assign lc_rise  = st_reg.lclk.s2 & ~st_reg.lclk_q;
	assign pdn      = st_reg.edpd & ~st_reg.nrg.s2;
	assign far_on   = st_reg.farlb & st_reg.rmii;
	assign mac_cut  = st_reg.ctl[pmc_pkg::CTL_ISO] | far_on | pdn;
	assign link_ok  = st_reg.ctl[pmc_pkg::CTL_SPD100] ?
		(st_reg.link_st == pmc_pkg::LNK_UP) : st_reg.l10.s2;
	assign last_sym = st_reg.win[4:0];
	assign lst_bits = st_reg.link_st;

	// next state of the whole block
	always_comb
	begin
		st_next = st_reg;
		// pin synchronisers
		st_next.lclk  = sync2(st_reg.lclk, link_clk);
		st_next.ten   = sync2(st_reg.ten, tx_en);
		st_next.ter   = sync2(st_reg.ter, tx_er);
		st_next.rxb   = sync2(st_reg.rxb, rx_code_bit);
		st_next.rdv   = sync2(st_reg.rdv, rx_line_dv);
		st_next.mlt   = sync2(st_reg.mlt, mlt3_signal_valid);
		st_next.l10   = sync2(st_reg.l10, link10_ok);
		st_next.nrg   = sync2(st_reg.nrg, line_energy_in);
		st_next.strap = sync2(st_reg.strap, rmii_strap);
		st_next.txd1  = txd;
		st_next.txd2  = st_reg.txd1;
		st_next.rd1   = rx_line_d;
		st_next.rd2   = st_reg.rd1;
		st_next.lclk_q = st_reg.lclk.s2;
		st_next.nrg_q  = st_reg.nrg.s2;
		// strap caught once the synchroniser has filled after release
		if (!st_reg.strap_done && st_reg.boot_cnt == 9'h002)
		begin
			st_next.rmii       = st_reg.strap.s2;
			st_next.strap_done = 1'b1;
		end
		// slow mac clock timer after any reset
		if (st_reg.boot_cnt != 9'(pmc_pkg::SLOW_CYC))
			st_next.boot_cnt = st_reg.boot_cnt + 9'h001;
		// soft reset completes in the cycle after it is written
		if (st_reg.ctl[pmc_pkg::CTL_SRST])
		begin
			st_next.ctl      = pmc_pkg::CTL_RST;
			st_next.farlb    = 1'b0;
			st_next.imask    = 1'b0;
			st_next.iflag    = 1'b0;
			st_next.boot_cnt = 9'h000;
			st_next.link_st  = pmc_pkg::LNK_DOWN;
			st_next.link_cnt = 14'h0000;
		end
		else if (wr)
		begin
			// register writes
			case (paddr)
				pmc_pkg::OFF_CTRL:
					st_next.ctl = pwdata[pmc_pkg::CTL_W-1:0];
				pmc_pkg::OFF_MODE:
				begin
					st_next.edpd  = pwdata[pmc_pkg::MOD_EDPD];
					st_next.farlb = pwdata[pmc_pkg::MOD_FARLB];
				end
				pmc_pkg::OFF_IMASK:
					st_next.imask = pwdata[0];
				pmc_pkg::OFF_ISRC:
					if (pwdata[0])
						st_next.iflag = 1'b0;
				default:
					st_next.ctl = st_reg.ctl;
			endcase
		end
		// energy wake event, set wins over clear
		if (st_reg.edpd && st_reg.nrg.s2 && !st_reg.nrg_q)
			st_next.iflag = 1'b1;
		// link monitor, restarted by valid loss or soft reset
		if (!st_reg.mlt.s2 || st_reg.ctl[pmc_pkg::CTL_SRST])
		begin
			st_next.link_st  = pmc_pkg::LNK_DOWN;
			st_next.link_cnt = 14'h0000;
		end
		else
		begin
			case (st_reg.link_st)
				pmc_pkg::LNK_DOWN:
				begin
					st_next.link_st  = pmc_pkg::LNK_WAIT;
					st_next.link_cnt = 14'h0001;
				end
				pmc_pkg::LNK_WAIT:
				begin
					st_next.link_cnt = st_reg.link_cnt + 14'h0001;
					if (st_reg.link_cnt >= 14'(LINK_WAIT))
						st_next.link_st = st_reg.ctl[pmc_pkg::CTL_ANEN] ?
							pmc_pkg::LNK_READY : pmc_pkg::LNK_UP;
				end
				pmc_pkg::LNK_READY:
					if (st_reg.ctl[pmc_pkg::CTL_ANEN])
						st_next.link_st = pmc_pkg::LNK_UP;
				pmc_pkg::LNK_UP:
					st_next.link_st = pmc_pkg::LNK_UP;
				default:
					st_next.link_st = pmc_pkg::LNK_DOWN;
			endcase
		end
		// link clock edge: code stream and mac data
		if (lc_rise)
		begin
			st_next.win = {st_reg.win[8:0], st_reg.rxb.s2};
			st_next.sym_cnt = (st_reg.sym_cnt == pmc_pkg::SYM_LAST) ?
				3'h0 : st_reg.sym_cnt + 3'h1;
			case (st_reg.cs_st)
				pmc_pkg::CS_IDLE:
					if (gap_zeros(st_reg.win))
						st_next.cs_st = pmc_pkg::CS_PRE;
				pmc_pkg::CS_PRE:
					if (st_reg.win == pmc_pkg::SYM_JK)
					begin
						st_next.cs_st   = pmc_pkg::CS_FRAME;
						st_next.sym_cnt = 3'h1;
					end
					else if (&st_reg.win)
						st_next.cs_st = pmc_pkg::CS_IDLE;
				pmc_pkg::CS_FRAME:
					if (st_reg.sym_cnt == 3'h0)
					begin
						if (last_sym == pmc_pkg::SYM_T)
							st_next.cs_st = pmc_pkg::CS_T;
						else if (last_sym == pmc_pkg::SYM_IDLE)
							st_next.cs_st = pmc_pkg::CS_I;
					end
				pmc_pkg::CS_T, pmc_pkg::CS_I:
					if (st_reg.sym_cnt == 3'h0)
					begin
						// end pair closes, anything else resumes
						if ((st_reg.cs_st == pmc_pkg::CS_T &&
							last_sym == pmc_pkg::SYM_R) ||
							(st_reg.cs_st == pmc_pkg::CS_I &&
							last_sym == pmc_pkg::SYM_IDLE))
						begin
							// drop spent delimiter zeros, else carrier restarts
							st_next.cs_st = pmc_pkg::CS_IDLE;
							st_next.win   = {9'h1ff, st_reg.rxb.s2};
						end
						else
							st_next.cs_st = pmc_pkg::CS_FRAME;
					end
				default:
					st_next.cs_st = pmc_pkg::CS_IDLE;
			endcase
			// mac transmit accepted only when connected
			st_next.tx_act = st_reg.ten.s2 & ~mac_cut;
			// line side transmit
			if (far_on)
			begin
				st_next.ltxen = st_reg.rdv.s2;
				st_next.ltxer = 1'b0;
				st_next.ltxd  = st_reg.rd2;
			end
			else if (mac_cut || st_reg.ctl[pmc_pkg::CTL_LPBK])
			begin
				st_next.ltxen = 1'b0;
				st_next.ltxer = 1'b0;
				st_next.ltxd  = 4'h0;
			end
			else
			begin
				st_next.ltxen = st_reg.ten.s2;
				st_next.ltxer = st_reg.ter.s2;
				st_next.ltxd  = st_reg.txd2;
			end
			// mac side receive
			if (st_reg.ctl[pmc_pkg::CTL_ISO] || far_on || pdn)
			begin
				st_next.rxdv = 1'b0;
				st_next.rxd  = 4'h0;
			end
			else if (st_reg.ctl[pmc_pkg::CTL_LPBK])
			begin
				st_next.rxdv = st_reg.ten.s2;
				st_next.rxd  = st_reg.txd2;
			end
			else
			begin
				st_next.rxdv = st_reg.rdv.s2 & link_ok;
				st_next.rxd  = st_reg.rd2;
			end
		end
		// receive carrier from the symbol state
		st_next.rx_crs = (st_reg.cs_st == pmc_pkg::CS_PRE) ||
			(st_reg.cs_st == pmc_pkg::CS_FRAME);
		// carrier: receive only in repeater or full duplex
		if (st_reg.ctl[pmc_pkg::CTL_RPT] || st_reg.ctl[pmc_pkg::CTL_FDX])
			st_next.crs = st_reg.rx_crs & ~mac_cut;
		else
			st_next.crs = (st_reg.rx_crs | st_reg.tx_act) & ~mac_cut;
		// collision
		if (st_reg.ctl[pmc_pkg::CTL_COLT])
			st_next.col = st_reg.ten.s2 & ~mac_cut;
		else if (st_reg.ctl[pmc_pkg::CTL_FDX] ||
			st_reg.ctl[pmc_pkg::CTL_LPBK] || mac_cut)
			st_next.col = 1'b0;
		else
			st_next.col = st_reg.tx_act & st_reg.rx_crs;
		// read data prepared in the setup phase
		st_next.prdata = 32'h0000_0000;
		if (setup)
		begin
			case (paddr)
				pmc_pkg::OFF_CTRL:
					st_next.prdata[pmc_pkg::CTL_W-1:0] = st_reg.ctl;
				pmc_pkg::OFF_MODE:
				begin
					st_next.prdata[pmc_pkg::MOD_EDPD]  = st_reg.edpd;
					st_next.prdata[pmc_pkg::MOD_FARLB] = st_reg.farlb;
					st_next.prdata[pmc_pkg::MOD_NRG]   = st_reg.nrg.s2;
				end
				pmc_pkg::OFF_STAT:
				begin
					st_next.prdata[pmc_pkg::STA_LINK] = link_ok;
					st_next.prdata[pmc_pkg::STA_PDN]  = pdn;
					st_next.prdata[pmc_pkg::STA_RMII] = st_reg.rmii;
					st_next.prdata[pmc_pkg::STA_FAST] = mac_clk_fast;
					st_next.prdata[pmc_pkg::STA_LST+:4] = lst_bits;
				end
				pmc_pkg::OFF_IMASK:
					st_next.prdata[0] = st_reg.imask;
				pmc_pkg::OFF_ISRC:
					st_next.prdata[0] = st_reg.iflag;
				default:
					st_next.prdata = 32'h0000_0000;
			endcase
		end
	end

	// state register, hardware reset clears all but ctl, link_st, cs_st and win, which load their reset values
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg          <= '0;
			st_reg.ctl      <= pmc_pkg::CTL_RST;
			st_reg.link_st  <= pmc_pkg::LNK_DOWN;
			st_reg.cs_st    <= pmc_pkg::CS_IDLE;
			st_reg.win      <= 10'h3ff;
		end
		else
			st_reg <= st_next;
	end

	// outputs
	assign prdata            = st_reg.prdata;
	assign pready            = 1'b1;
	assign pslverr           = acc & ~mapped;
	assign rx_dv             = st_reg.rxdv;
	assign rxd               = st_reg.rxd;
	assign crs               = st_reg.crs & ~st_reg.rmii;
	assign crs_dv            = (st_reg.crs | st_reg.rxdv) & st_reg.rmii;
	assign col               = st_reg.col;
	assign line_tx_en        = st_reg.ltxen;
	assign line_tx_er        = st_reg.ltxer;
	assign line_txd          = st_reg.ltxd;
	assign tx_power_down     = pdn | st_reg.ctl[pmc_pkg::CTL_LPBK];
	assign core_power_down   = pdn;
	assign mac_clk_fast      = (st_reg.boot_cnt == 9'(pmc_pkg::SLOW_CYC)) &
		st_reg.ctl[pmc_pkg::CTL_ANEN];
	assign link_data_enable  = (st_reg.link_st == pmc_pkg::LNK_UP);
	assign link_activity_led = link_ok;
	assign interrupt_out_n   = ~(st_reg.iflag & st_reg.imask);
endmodule : pmc_core
`default_nettype wire

/* dv/pmc_core_props.sv */
// checker for the misc mode control block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module pmc_core_props #(
	parameter int LINK_WAIT = pmc_pkg::LINK_WAIT_CYC // line settle count
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        tx_en,
	input wire logic        mlt3_signal_valid,
	input wire logic        line_energy_in,
	input wire logic        col,
	input wire logic        line_tx_en,
	input wire logic        tx_power_down,
	input wire logic        core_power_down,
	input wire logic        mac_clk_fast,
	input wire logic        link_data_enable,
	input wire logic        interrupt_out_n
);
	localparam int SLOW_MIN = pmc_pkg::SLOW_CYC - 2; // sync slack
	logic [7:0]  ctrl_s;   // control as written
	logic        mode_s;   // power-down enable as written
	logic        mask_s;   // energy interrupt mask as written
	logic        srst_d;   // soft reset, one cycle late
	logic [15:0] slow_cnt; // cycles since a reset
	logic [15:0] link_cnt; // cycles with valid signal high
	logic        wr;       // write taking effect
	assign wr = psel && penable && pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow of written bits and the two counters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_s <= pmc_pkg::CTL_RST;
			mode_s <= 1'b0;
			mask_s <= 1'b0;
			srst_d <= 1'b0;
			slow_cnt <= 16'h0000;
			link_cnt <= 16'h0000;
		end
		else
		begin
			srst_d <= wr && paddr == pmc_pkg::OFF_CTRL && pwdata[0];
			if (wr && paddr == pmc_pkg::OFF_CTRL)
				ctrl_s <= pwdata[0] ? pmc_pkg::CTL_RST : pwdata[7:0];
			if (wr && paddr == pmc_pkg::OFF_MODE)
				mode_s <= pwdata[pmc_pkg::MOD_EDPD];
			if (srst_d)
				mask_s <= 1'b0; // soft reset clears the mask
			else if (wr && paddr == pmc_pkg::OFF_IMASK)
				mask_s <= pwdata[0];
			slow_cnt <= srst_d ? 16'h0000 : slow_cnt + {15'h0, ~&slow_cnt};
			link_cnt <= !mlt3_signal_valid ? 16'h0000
				: link_cnt + {15'h0, ~&link_cnt};
		end
	end
	// energy gone long enough to settle
	sequence s_no_energy;
		(mode_s && !line_energy_in) [*6];
	endsequence
	// isolate held over two cycles
	sequence s_iso_held;
		ctrl_s[pmc_pkg::CTL_ISO] ##1 ctrl_s[pmc_pkg::CTL_ISO];
	endsequence
	chk_edpd_gate: assert property (!mode_s && !$past(mode_s)
		|-> !core_power_down) else $error("power-down while disabled");
	chk_edpd_sleep: assert property (s_no_energy
		|-> core_power_down && tx_power_down) else $error("still awake");
	chk_wake_mask: assert property ($fell(interrupt_out_n)
		|-> mask_s) else $error("interrupt while masked");
	chk_iso_quiet: assert property (s_iso_held
		|-> !$rose(line_tx_en)) else $error("transmit while isolated");
	chk_slow_start: assert property ($rose(mac_clk_fast)
		|-> slow_cnt >= SLOW_MIN) else $error("fast clock too soon");
	chk_col_fdx: assert property ((ctrl_s[pmc_pkg::CTL_FDX]
		&& !ctrl_s[pmc_pkg::CTL_COLT]) [*3] |-> !col) else $error("col");
	chk_colt_on: assert property (ctrl_s[pmc_pkg::CTL_COLT]
		&& !ctrl_s[pmc_pkg::CTL_FDX] && !ctrl_s[pmc_pkg::CTL_ISO]
		&& !mode_s && $rose(tx_en) |-> ##[1:8] col)
		else $error("collision test late");
	chk_link_wait: assert property ($rose(link_data_enable)
		|-> link_cnt >= LINK_WAIT) else $error("link up too soon");
	chk_link_drop: assert property ($fell(mlt3_signal_valid)
		|-> ##[1:5] !link_data_enable) else $error("link held");
	chk_lpbk_txoff: assert property (ctrl_s[pmc_pkg::CTL_LPBK]
		|-> tx_power_down) else $error("transmitters on in loopback");
endmodule : pmc_core_props
bind pmc_core pmc_core_props #(.LINK_WAIT(LINK_WAIT)) pmc_core_props_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_en(tx_en),
	.mlt3_signal_valid(mlt3_signal_valid), .col(col),
	.line_energy_in(line_energy_in), .line_tx_en(line_tx_en),
	.tx_power_down(tx_power_down), .core_power_down(core_power_down),
	.mac_clk_fast(mac_clk_fast), .link_data_enable(link_data_enable),
	.interrupt_out_n(interrupt_out_n));
`default_nettype wire

/* dv/pmc_mac_model.sv */
// mac model: sends frames and runs the link clock only when asked
`timescale 1ns/1ps
`default_nettype none
module pmc_mac_model (
	input  wire logic       start,    // begin one frame
	input  wire logic       run,      // keep the clock for receive
	output logic            busy,     // frame in progress
	output logic            link_clk, // bit clock, 320 ns
	output logic            tx_en,    // transmit enable
	output logic            tx_er,    // never flags errors
	output logic      [3:0] txd       // transmit nibble
);
	localparam int NIB = 6; // nibbles per frame
	int i;
	// clock stands still unless a frame is busy or run is set, odd phase to pclk
	initial
	begin
		link_clk = 1'b0;
		forever
		begin
			wait (busy || run);
			#7;
			while (busy || run)
			begin
				#160 link_clk = 1'b1;
				#160 link_clk = 1'b0;
			end
		end
	end
	// frame sender; nothing checks the first frames after a wake
	initial
	begin
		busy = 1'b0;
		tx_en = 1'b0;
		tx_er = 1'b0;
		txd = 4'h5;
		forever
		begin
			@(posedge start);
			busy = 1'b1;
			for (i = 0; i < NIB + 2; i++)
			begin
				tx_en = i < NIB;
				txd = tx_en ? i[3:0] : ~txd; // idle data flips
				@(negedge link_clk);
			end
			busy = 1'b0;
		end
	end
endmodule : pmc_mac_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the misc mode control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int LW = 20; // shortened settle count
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        rx_code_bit, rx_line_dv, mlt3, link10_ok, energy, run;
	logic        link_clk, tx_en, tx_er, start, busy, rx_dv, crs, crs_dv;
	logic        col, line_tx_en, tx_pd, core_pd, fast, lde, led, int_n;
	logic [3:0]  txd;
	logic        strap;    // rmii mode strap pin
	int          n_errors = 0, tests_run = 0, n_tx = 0, n_rx = 0, n_col = 0;
	int          b_tx, b_rx, b_col;
	logic [7:0]  cv [5] = '{8'h90, 8'h92, 8'h94, 8'h98, 8'hb0}; // ctrl
	logic [2:0]  ex [5] = '{3'b100, 3'b000, 3'b010, 3'b101, 3'b110};
	logic [2:0]  em [5] = '{3'b111, 3'b111, 3'b011, 3'b101, 3'b111};
	pmc_core #(.LINK_WAIT(LW)) pmc_core_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rmii_strap(strap), .link_clk(link_clk),
		.tx_en(tx_en), .tx_er(tx_er), .txd(txd), .rx_code_bit(rx_code_bit),
		.rx_line_dv(rx_line_dv), .rx_line_d(4'h0), .mlt3_signal_valid(mlt3),
		.link10_ok(link10_ok), .line_energy_in(energy), .rx_dv(rx_dv),
		.rxd(), .crs(crs), .crs_dv(crs_dv), .col(col), .line_txd(),
		.line_tx_en(line_tx_en), .line_tx_er(), .tx_power_down(tx_pd),
		.core_power_down(core_pd), .mac_clk_fast(fast),
		.link_data_enable(lde), .link_activity_led(led),
		.interrupt_out_n(int_n));
	pmc_mac_model pmc_mac_model_inst (.start(start), .run(run),
		.busy(busy), .link_clk(link_clk), .tx_en(tx_en), .tx_er(tx_er),
		.txd(txd));
	// free running pclk
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// count cycles with transmit, receive and collision seen
	always @(posedge pclk)
	begin
		n_tx <= n_tx + int'(line_tx_en === 1'b1);
		n_rx <= n_rx + int'(rx_dv === 1'b1);
		n_col <= n_col + int'(col === 1'b1);
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer, one edge after the last release
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (k == 16)
			n_errors++;
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] msk);
		apb(1'b0, a, 32'h0);
		chk(rd & msk, exp);
	endtask : rdchk
	// one mac frame, waited for under a bound
	task automatic frame();
		int k;
		b_tx = n_tx;
		b_rx = n_rx;
		b_col = n_col;
		start <= 1'b1;
		repeat (4) @(posedge pclk);
		start <= 1'b0;
		for (k = 0; k < 300 && busy === 1'b1; k++)
			@(posedge pclk);
		repeat (8) @(posedge pclk);
	endtask : frame
	// code bits, first bit first, one link clock period each
	task automatic bits(input logic [9:0] v);
		for (int b = 9; b >= 0; b--)
		begin
			rx_code_bit <= v[b];
			repeat (8) @(posedge pclk);
		end
	endtask : bits
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// watchdog
	initial
	begin
		#(40 * 20000);
		n_errors++;
		conclude();
	end
	// main sequence
	initial
	begin
		presetn = 1'b0; // reset with the clock running
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rx_code_bit, energy, rx_line_dv, mlt3, link10_ok} = 5'b11000;
		{run, start, strap} = 3'b000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (pmc_pkg::SLOW_CYC - 10) @(posedge pclk);
		chk(fast, 1'b0);
		repeat (20) @(posedge pclk);
		chk(fast, 1'b1);
		rdchk(pmc_pkg::OFF_CTRL, 32'h90, 32'hff);
		apb(1'b0, 8'h14, 32'h0);
		chk(slv, 1'b1);
		chk(rd, 32'h0);
		mlt3 <= 1'b1;
		repeat (LW) @(posedge pclk);
		chk(lde, 1'b0);
		repeat (LW) @(posedge pclk);
		chk({lde, led}, 2'b11);
		rdchk(pmc_pkg::OFF_STAT, 32'h1, 32'h1);
		mlt3 <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({lde, led}, 2'b00);
		apb(1'b1, pmc_pkg::OFF_CTRL, 32'h10);
		link10_ok <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(led, 1'b1);
		link10_ok <= 1'b0;
		mlt3 <= 1'b1;
		repeat (3 * LW) @(posedge pclk);
		foreach (cv[i])
		begin
			apb(1'b1, pmc_pkg::OFF_CTRL, {24'h0, cv[i]});
			rx_line_dv <= cv[i][5];
			frame();
			chk({n_tx > b_tx, n_rx > b_rx, n_col > b_col} & em[i], ex[i]);
			rdchk(pmc_pkg::OFF_CTRL, {24'h0, cv[i]}, 32'hff);
		end
		rx_line_dv <= 1'b0;
		energy <= 1'b0;
		repeat (8) @(posedge pclk);
		chk(core_pd, 1'b0);
		apb(1'b1, pmc_pkg::OFF_IMASK, 32'h1);
		apb(1'b1, pmc_pkg::OFF_MODE, 32'h1);
		repeat (8) @(posedge pclk);
		chk({core_pd, tx_pd}, 2'b11);
		energy <= 1'b1;
		repeat (8) @(posedge pclk);
		chk({core_pd, int_n}, 2'b00);
		rdchk(pmc_pkg::OFF_ISRC, 32'h1, 32'h1);
		apb(1'b1, pmc_pkg::OFF_ISRC, 32'h1);
		repeat (2) @(posedge pclk);
		chk(int_n, 1'b1);
		rdchk(pmc_pkg::OFF_IMASK, 32'h1, 32'h1);
		apb(1'b1, pmc_pkg::OFF_CTRL, 32'h93);
		rdchk(pmc_pkg::OFF_CTRL, 32'h90, 32'hff);
		rdchk(pmc_pkg::OFF_MODE, 32'h1, 32'h3);
		rdchk(pmc_pkg::OFF_IMASK, 32'h0, 32'h1);
		chk(fast, 1'b0);
		run <= 1'b1;
		bits(pmc_pkg::SYM_JK);
		bits(10'h3de);
		chk({crs, crs_dv}, 2'b10);
		bits({pmc_pkg::SYM_T, 5'h1e});
		chk(crs, 1'b0);
		bits(10'h3de);
		chk(crs, 1'b1);
		bits({pmc_pkg::SYM_T, pmc_pkg::SYM_R});
		bits({pmc_pkg::SYM_IDLE, pmc_pkg::SYM_IDLE});
		chk(crs, 1'b0);
		bits(10'h2bf);
		chk(crs, 1'b1);
		bits(10'h3ff);
		repeat (32) @(posedge pclk);
		chk(crs, 1'b0);
		run <= 1'b0;
		// second hardware reset with the rmii strap, then far loopback
		strap <= 1'b1;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		rdchk(pmc_pkg::OFF_STAT, 32'h4, 32'h4);
		apb(1'b1, pmc_pkg::OFF_MODE, 32'h2);
		rx_line_dv <= 1'b1;
		frame();
		chk({n_tx > b_tx, n_rx > b_rx}, 2'b10);
		conclude();
	end
endmodule : testbench
`default_nettype wire

/* pkg/pmc_pkg.sv */
// constants and types shared by the phy misc mode control block
package pmc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00; // basic control
	localparam logic [7:0] OFF_MODE    = 8'h04; // mode control and status
	localparam logic [7:0] OFF_STAT    = 8'h08; // basic status
	localparam logic [7:0] OFF_IMASK   = 8'h0c; // interrupt mask
	localparam logic [7:0] OFF_ISRC    = 8'h10; // interrupt source, w1c
	// control register field positions
	localparam int CTL_SRST   = 0; // soft reset, self clearing
	localparam int CTL_ISO    = 1; // isolate
	localparam int CTL_LPBK   = 2; // near-end loopback
	localparam int CTL_COLT   = 3; // collision test
	localparam int CTL_ANEN   = 4; // auto-negotiation enable
	localparam int CTL_FDX    = 5; // full duplex
	localparam int CTL_RPT    = 6; // repeater mode
	localparam int CTL_SPD100 = 7; // 100 mbit speed
	localparam int CTL_W      = 8; // control width
	// mode register field positions
	localparam int MOD_EDPD   = 0; // energy detect power-down enable
	localparam int MOD_FARLB  = 1; // far loopback enable
	localparam int MOD_NRG    = 2; // line energy present, read only
	// status register field positions
	localparam int STA_LINK   = 0; // combined link status
	localparam int STA_PDN    = 1; // powered down by energy detect
	localparam int STA_RMII   = 2; // rmii mode strap
	localparam int STA_FAST   = 3; // mac interface at 25 mhz
	localparam int STA_LST    = 4; // link state, four bits
	// values after reset
	localparam logic [CTL_W-1:0] CTL_RST = 8'h90; // 100 mbit, aneg on
	// symbol codes, first bit in the msb
	localparam logic [9:0] SYM_JK   = 10'h311; // 11000 10001
	localparam logic [4:0] SYM_T    = 5'h0d;   // 01101
	localparam logic [4:0] SYM_R    = 5'h07;   // 00111
	localparam logic [4:0] SYM_IDLE = 5'h1f;   // 11111
	localparam logic [2:0] SYM_LAST = 3'h4;    // last bit index of symbol
	// timing
	localparam int CLK_MHZ      = 25;  // pclk rate
	localparam int SLOW_TIME_US = 16;  // slow mac clock after reset
	localparam int SLOW_CYC     = SLOW_TIME_US * CLK_MHZ;
	localparam int LINK_WAIT_US = 330; // line settle before link ready
	localparam int LINK_WAIT_CYC = LINK_WAIT_US * CLK_MHZ;
	// link monitor states
	typedef enum logic [3:0] {
		LNK_DOWN  = 4'b0001,
		LNK_WAIT  = 4'b0010,
		LNK_READY = 4'b0100,
		LNK_UP    = 4'b1000
	} pmc_link_t;
	// carrier sense states
	typedef enum logic [4:0] {
		CS_IDLE  = 5'b00001,
		CS_PRE   = 5'b00010,
		CS_FRAME = 5'b00100,
		CS_T     = 5'b01000,
		CS_I     = 5'b10000
	} pmc_cs_t;
endpackage : pmc_pkg
